// File: host_port_pkg.sv
// Constants shared by the host access port handshake logic.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package host_port_pkg;

   // ************************************************************
   // Access select codes
   // ************************************************************
   localparam logic [1:0] SEL_CONTROL    = 2'h0;
   localparam logic [1:0] SEL_DATA_INC   = 2'h1;
   localparam logic [1:0] SEL_ADDRESS    = 2'h2;
   localparam logic [1:0] SEL_DATA_FIXED = 2'h3;

   localparam logic       HALF_FIRST     = 1'h0;
   localparam logic       ACCESS_READ    = 1'h1;

   // ************************************************************
   // Widths, reset values and steps
   // ************************************************************
   localparam int          HALF_W          = 16;
   localparam int          WORD_W          = 32;
   localparam logic [31:0] ADDRESS_STEP    = 32'h0000_0004;
   localparam logic [31:0] ADDRESS_RESET   = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET      = 32'h0000_0000;
   localparam logic [15:0] CONTROL_RESET   = 16'h0000;

   // ************************************************************
   // Positions of the asynchronous pins in the synchroniser vector
   // ************************************************************
   localparam int SYNC_DATA_LO = 0;
   localparam int SYNC_SEL_LO  = 16;
   localparam int SYNC_HALF    = 18;
   localparam int SYNC_RW      = 19;
   localparam int SYNC_ADDR_ST = 20;
   localparam int SYNC_DS_TWO  = 21;
   localparam int SYNC_DS_ONE  = 22;
   localparam int SYNC_CS      = 23;
   localparam int SYNC_W       = 24;

   // ************************************************************
   // Handshake states
   // ************************************************************
   typedef enum logic [4:0] {
      ST_IDLE    = 5'b00001,
      ST_FETCH   = 5'b00010,
      ST_LOAD    = 5'b00100,
      ST_STORE   = 5'b01000,
      ST_ADVANCE = 5'b10000
   } port_state_t;

endpackage

// File: host_port_handshake.sv
// Host access port: 16-bit asynchronous host side, 32-bit word side toward the auxiliary DMA channel.
// Assumes the auxiliary channel answers each held request with a one-cycle acknowledge on ref_clk.
//
// Function
// RULE_01 - Strobe low only when selected, one data strobe.
// RULE_02 - Ready held low while chip select high.
// RULE_03 - Busy at chip select fall shows not ready.
// RULE_04 - First read half requests word, stalls until loaded.
// RULE_05 - Control and address accesses never touch ready.
// RULE_06 - Only data writes and data reads raise ready.
// RULE_07 - Second half of word stalls while word completes.
// RULE_08 - Host holds strobe until ready falls low.
// RULE_09 - Selects captured at strobe falling edge.
// RULE_10 - Read data driven after fall, released after rise.
// RULE_11 - Optional address strobe latches selects earlier.
// RULE_12 - Host pins pass two flip-flops first.
module host_port_handshake
   import host_port_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                port_chip_select_n,
   input  wire logic                data_strobe_one,
   input  wire logic                data_strobe_two,
   input  wire logic                address_strobe_n,
   input  wire logic [1:0]          register_select,
   input  wire logic                read_write_select,
   input  wire logic                halfword_select,
   input  wire logic [HALF_W-1:0]   port_data_bus_in,
   output logic      [HALF_W-1:0]   port_data_bus_out,
   output logic                     port_data_bus_oe,
   output logic                     port_ready_n,
   output logic                     aux_req,
   output logic                     aux_write,
   output logic      [WORD_W-1:0]   aux_addr,
   output logic      [WORD_W-1:0]   aux_wdata,
   input  wire logic                aux_ack,
   input  wire logic [WORD_W-1:0]   aux_rdata
);

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic logic is_data_sel(input logic [1:0] sel);
      is_data_sel = (sel == SEL_DATA_INC) || (sel == SEL_DATA_FIXED);
   endfunction

   function automatic logic [WORD_W-1:0] put_half(input logic [WORD_W-1:0] word,
                                                 input logic               half,
                                                 input logic [HALF_W-1:0]  value);
      logic [WORD_W-1:0] merged;
      merged = word;
      if (half == HALF_FIRST) begin
         merged[HALF_W-1:0] = value;
      end else begin
         merged[WORD_W-1:HALF_W] = value;
      end
      put_half = merged;
   endfunction

   function automatic logic [HALF_W-1:0] get_half(input logic [WORD_W-1:0] word,
                                                 input logic              half);
      get_half = (half == HALF_FIRST) ? word[HALF_W-1:0] : word[WORD_W-1:HALF_W];
   endfunction

   // ************************************************************
   // Synchronisers
   // ************************************************************
   logic [SYNC_W-1:0]   raw_pins;
   logic [SYNC_W-1:0]   sync_first;
   logic [SYNC_W-1:0]   sync_second;

   assign raw_pins = {port_chip_select_n, data_strobe_one, data_strobe_two, address_strobe_n,
                      read_write_select, halfword_select, register_select, port_data_bus_in};

   // The host is free-running against ref_clk, so every pin is resynchronised.
   // Data and selects are held by the host around the strobe edges, so a
   // skewed capture of a multi-bit group settles before it is used.
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sync_first[gi]  <= 1'h1;
               sync_second[gi] <= 1'h1;
            end else begin
               sync_first[gi]  <= raw_pins[gi];  // RULE_12
               sync_second[gi] <= sync_first[gi];  // RULE_12
            end
         end
      end
   endgenerate

   logic                cs_n_s;
   logic                strobe_n;
   logic                addr_st_n_s;
   logic [1:0]          sel_s;
   logic                rw_s;
   logic                half_s;
   logic [HALF_W-1:0]   data_s;

   assign cs_n_s      = sync_second[SYNC_CS];
   assign addr_st_n_s = sync_second[SYNC_ADDR_ST];
   assign sel_s       = sync_second[SYNC_SEL_LO +: 2];
   assign rw_s        = sync_second[SYNC_RW];
   assign half_s      = sync_second[SYNC_HALF];
   assign data_s      = sync_second[SYNC_DATA_LO +: HALF_W];
   assign strobe_n    = ~(sync_second[SYNC_DS_ONE] ^ sync_second[SYNC_DS_TWO]) | cs_n_s;  // RULE_01

   // ************************************************************
   // Edge detection
   // ************************************************************
   logic strobe_q;
   logic addr_st_q;
   logic strobe_fall;
   logic strobe_rise;
   logic addr_st_fall;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strobe_q  <= 1'h1;
         addr_st_q <= 1'h1;
      end else begin
         strobe_q  <= strobe_n;
         addr_st_q <= addr_st_n_s;
      end
   end

   assign strobe_fall  = strobe_q & ~strobe_n;
   assign strobe_rise  = ~strobe_q & strobe_n;
   assign addr_st_fall = addr_st_q & ~addr_st_n_s;

   // ************************************************************
   // Select capture
   // ************************************************************
   logic [1:0] held_sel;
   logic       held_rw;
   logic       held_half;
   logic       held_valid;
   logic [1:0] acc_sel;
   logic       acc_rw;
   logic       acc_half;
   logic [1:0] cur_sel;
   logic       cur_rw;
   logic       cur_half;

   // A tied-high address strobe never falls, so the strobe edge alone captures.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         held_valid <= 1'h0;
         held_sel   <= SEL_CONTROL;
         held_rw    <= ACCESS_READ;
         held_half  <= HALF_FIRST;
      end else if (addr_st_fall) begin
         held_valid <= 1'h1;  // RULE_11
         held_sel   <= sel_s;
         held_rw    <= rw_s;
         held_half  <= half_s;
      end else if (strobe_rise) begin
         held_valid <= 1'h0;
      end
   end

   assign acc_sel  = held_valid ? held_sel  : sel_s;  // RULE_11
   assign acc_rw   = held_valid ? held_rw   : rw_s;
   assign acc_half = held_valid ? held_half : half_s;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_sel  <= SEL_CONTROL;
         cur_rw   <= ACCESS_READ;
         cur_half <= HALF_FIRST;
      end else if (strobe_fall) begin
         cur_sel  <= acc_sel;  // RULE_09
         cur_rw   <= acc_rw;  // RULE_09
         cur_half <= acc_half;  // RULE_09
      end
   end

   // ************************************************************
   // Handshake state machine
   // ************************************************************
   port_state_t state;
   port_state_t next_state;
   logic        start_fetch;
   logic        start_finish;
   logic        finish_write;

   assign start_fetch  = strobe_fall && (acc_rw == ACCESS_READ) && is_data_sel(acc_sel)
                         && (acc_half == HALF_FIRST);
   assign finish_write = cur_rw != ACCESS_READ;
   assign start_finish = strobe_rise && is_data_sel(cur_sel) && (cur_half != HALF_FIRST)
                         && (finish_write || (cur_sel == SEL_DATA_INC));

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start_fetch) begin
               next_state = ST_FETCH;  // RULE_04
            end else if (start_finish && finish_write) begin
               next_state = ST_STORE;  // RULE_07
            end else if (start_finish) begin
               next_state = ST_ADVANCE;  // RULE_07
            end
         end
         ST_FETCH: begin
            if (aux_ack) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            next_state = ST_IDLE;
         end
         ST_STORE: begin
            if (aux_ack) begin
               next_state = (cur_sel == SEL_DATA_INC) ? ST_ADVANCE : ST_IDLE;
            end
         end
         ST_ADVANCE: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Port registers
   // ************************************************************
   logic [WORD_W-1:0] data_word;
   logic [WORD_W-1:0] address_word;
   logic [HALF_W-1:0] control_word;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_word <= DATA_RESET;
      end else if (state == ST_FETCH && aux_ack) begin
         data_word <= aux_rdata;  // RULE_04
      end else if (strobe_rise && finish_write && is_data_sel(cur_sel)) begin
         data_word <= put_half(data_word, cur_half, data_s);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         address_word <= ADDRESS_RESET;
      end else if (state == ST_ADVANCE) begin
         address_word <= address_word + ADDRESS_STEP;
      end else if (strobe_rise && finish_write && cur_sel == SEL_ADDRESS) begin
         address_word <= put_half(address_word, cur_half, data_s);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         control_word <= CONTROL_RESET;
      end else if (strobe_rise && finish_write && cur_sel == SEL_CONTROL) begin
         control_word <= data_s;
      end
   end

   // ************************************************************
   // Auxiliary channel request
   // ************************************************************
   assign aux_req   = (state == ST_FETCH) || (state == ST_STORE);
   assign aux_write = state == ST_STORE;
   assign aux_addr  = address_word;
   assign aux_wdata = data_word;

   // ************************************************************
   // Host data bus
   // ************************************************************
   logic read_active;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         read_active <= 1'h0;
      end else if (strobe_fall) begin
         read_active <= acc_rw == ACCESS_READ;  // RULE_10
      end else if (strobe_rise) begin
         read_active <= 1'h0;  // RULE_10
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         port_data_bus_out <= CONTROL_RESET;
      end else if (cur_sel == SEL_CONTROL) begin
         port_data_bus_out <= control_word;
      end else if (cur_sel == SEL_ADDRESS) begin
         port_data_bus_out <= get_half(address_word, cur_half);
      end else begin
         port_data_bus_out <= get_half(data_word, cur_half);
      end
   end

   assign port_data_bus_oe = read_active;

   // ************************************************************
   // Ready
   // ************************************************************
   // Ready is combinational so that it rises in the same cycle as the strobe
   // edge is seen; only data-register traffic ever reaches the busy term.
   // The host must hold the strobe until ready falls, otherwise a read
   // can return its first half before the word has been loaded.
   logic busy;

   assign busy         = (state != ST_IDLE) || start_fetch || start_finish;  // RULE_03 RULE_06 RULE_05
   assign port_ready_n = ~cs_n_s & busy;  // RULE_02 RULE_08

endmodule

// File: host_port_handshake_monitor.sv
// Concurrent checks on the host port handshake, bound to the design top.
// Assumes one clock and the synchronous reset of the design.
module host_port_handshake_monitor
   import host_port_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              port_chip_select_n,
   input wire logic              data_strobe_one,
   input wire logic              data_strobe_two,
   input wire logic [1:0]        register_select,
   input wire logic              read_write_select,
   input wire logic              port_data_bus_oe,
   input wire logic              port_ready_n,
   input wire logic              aux_req,
   input wire logic              aux_write,
   input wire logic [WORD_W-1:0] aux_addr,
   input wire logic              aux_ack
);
   // ************************************************************
   // Checks
   // ************************************************************
   logic strb;
   logic data_sel;
   assign strb = ~(data_strobe_one ^ data_strobe_two) | port_chip_select_n;
   assign data_sel = (register_select == SEL_DATA_INC) || (register_select == SEL_DATA_FIXED);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Chip select passes two synchroniser flops, so its effect shows on the third sample.
   a_ready_cs_gate: assert property (port_chip_select_n [*3] |-> !port_ready_n)
      else $error("ready shown while deselected");
   a_req_held: assert property (aux_req && !aux_ack |=> aux_req && $stable(aux_addr) && $stable(aux_write))
      else $error("word request dropped or changed");
   a_busy_req: assert property ((!port_chip_select_n [*3] ##0 aux_req) |-> port_ready_n)
      else $error("ready low while word pending");
   a_ack_done: assert property (aux_ack && aux_req |-> ##[1:2] (!port_ready_n || port_chip_select_n))
      else $error("ready stuck after acknowledge");
   // Seven edges cover the two synchroniser stages, the edge detect and the register.
   a_oe_release: assert property (strb [*7] |-> !port_data_bus_oe)
      else $error("bus driven after strobe rise");
   a_oe_start: assert property ($rose(port_data_bus_oe) |-> !strb && read_write_select)
      else $error("bus driven without read strobe");
   a_req_dir: assert property ($rose(aux_req) |-> aux_write == !read_write_select)
      else $error("word direction differs from select");
   a_req_data: assert property (aux_req |-> data_sel)
      else $error("word request on non-data access");
   a_ready_data: assert property ($rose(port_ready_n) |-> data_sel)
      else $error("ready raised on non-data access");
   c_read_word: cover property (aux_ack && !aux_write);
   c_write_word: cover property (aux_ack && aux_write);
   c_busy_probe: cover property ($fell(port_chip_select_n) ##2 port_ready_n);
endmodule

// File: aux_chan_model.sv
// Behavioural auxiliary DMA channel: sixteen words, acknowledge after lag cycles.
// Assumes the same clock as the port and a request held until acknowledged.
module aux_chan_model
   import host_port_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              aux_req,
   input wire logic              aux_write,
   input wire logic [WORD_W-1:0] aux_addr,
   input wire logic [WORD_W-1:0] aux_wdata,
   input wire logic [3:0]        lag,
   output logic                  aux_ack,
   output logic     [WORD_W-1:0] aux_rdata
);
   logic [WORD_W-1:0] mem [16];
   logic [3:0]        waited;
   initial begin
      aux_ack = 1'b0;
      aux_rdata = '0;
      waited = 4'h0;
      foreach (mem[i]) mem[i] = '0;
   end
   // Read data toggles outside the acknowledge so a late sample cannot pass.
   always @(posedge ref_clk) begin
      aux_ack <= 1'b0;
      aux_rdata <= ~aux_rdata;
      waited <= 4'h0;
      if (aux_req && !aux_ack) begin
         waited <= waited + 4'h1;
         if (waited >= lag) begin
            aux_ack <= 1'b1;
            if (aux_write) mem[aux_addr[5:2]] <= aux_wdata;
            else aux_rdata <= mem[aux_addr[5:2]];
         end
      end
   end
endmodule

// File: host_port_handshake_tb_top.sv
// Self-checking bench: host accesses against the design and a channel model.
// Assumes the package, design, checker and model are compiled first.
module host_port_handshake_tb_top
   import host_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk, rst, port_chip_select_n, data_strobe_one, data_strobe_two;
   logic              address_strobe_n, read_write_select, halfword_select, oe_d, seen_busy;
   logic [1:0]        register_select;
   logic [15:0]       port_data_bus_in, port_data_bus_out, last_out, exp_v, ctl;
   logic              port_data_bus_oe, port_ready_n, aux_req, aux_write, aux_ack;
   logic [WORD_W-1:0] aux_addr, aux_wdata, aux_rdata, rnd, w0, w1, a;
   logic [3:0]        lag;
   logic [15:0]       exp_q [$];
   int                n_fail, cmp_count;
   host_port_handshake host_port_handshake_inst (.ref_clk, .rst, .port_chip_select_n, .data_strobe_one,
      .data_strobe_two, .address_strobe_n, .register_select, .read_write_select, .halfword_select,
      .port_data_bus_in, .port_data_bus_out, .port_data_bus_oe, .port_ready_n, .aux_req, .aux_write,
      .aux_addr, .aux_wdata, .aux_ack, .aux_rdata);
   aux_chan_model aux_chan_model_inst (.ref_clk, .aux_req, .aux_write, .aux_addr, .aux_wdata, .lag,
      .aux_ack, .aux_rdata);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task wait_low;
      int k;
      k = 0;
      @(negedge ref_clk);
      while (port_ready_n !== 1'b0) begin
         @(negedge ref_clk);
         k++;
         if (k > 300) begin
            n_fail++;
            $display("unexpected at %0t: ready never low", $time);
            stop_test();
         end
      end
   endtask
   // One half-word access; the strobe is held until ready is low, as a real host must.
   task acc(input logic [1:0] sel, input logic rw, h, input logic [15:0] wd, input logic as_on,
            input logic [15:0] ex);
      wait_low();
      @(posedge ref_clk);
      register_select <= sel;
      read_write_select <= rw;
      halfword_select <= h;
      port_data_bus_in <= wd;
      if (as_on) begin
         address_strobe_n <= 1'b0;
         repeat (5) @(posedge ref_clk);
         register_select <= sel ^ 2'h2;
      end
      if (rw) exp_q.push_back(ex);
      @(posedge ref_clk);
      if (h) data_strobe_two <= 1'b0;
      else data_strobe_one <= 1'b0;
      repeat (6) @(posedge ref_clk);
      wait_low();
      @(posedge ref_clk);
      data_strobe_one <= 1'b1;
      data_strobe_two <= 1'b1;
      address_strobe_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask
   task wr_word(input logic [1:0] sel, input logic [31:0] w);
      acc(sel, 1'b0, HALF_FIRST, w[15:0], 1'b0, 16'h0000);
      acc(sel, 1'b0, ~HALF_FIRST, w[31:16], 1'b0, 16'h0000);
   endtask
   task rd_word(input logic [1:0] sel, input logic [31:0] w);
      acc(sel, ACCESS_READ, HALF_FIRST, 16'h0000, 1'b0, w[15:0]);
      acc(sel, ACCESS_READ, ~HALF_FIRST, 16'h0000, 1'b0, w[31:16]);
   endtask
   task done(input string name);
      $display("test %s done at %0t", name, $time);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) if (port_ready_n === 1'b1) seen_busy = 1'b1;
   // Each read result is taken when the device lets go of the bus.
   always @(posedge ref_clk) begin
      if (port_data_bus_oe === 1'b1) last_out <= port_data_bus_out;
      if (oe_d === 1'b1 && port_data_bus_oe !== 1'b1) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~last_out;
         chk(last_out, exp_v);
      end
      oe_d <= port_data_bus_oe;
   end
   initial begin
      {rst, port_chip_select_n, data_strobe_one, data_strobe_two, address_strobe_n} = 5'h1F;
      {read_write_select, halfword_select, oe_d, seen_busy, register_select} = 6'h00;
      port_data_bus_in = 16'h0000;
      lag = 4'h0;
      rnd = 32'h0001_7B9F;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk(16'(port_ready_n), 16'h0000);
      chk(16'(aux_req), 16'h0000);
      @(posedge ref_clk);
      port_chip_select_n <= 1'b0;
      data_strobe_one <= 1'b0;
      data_strobe_two <= 1'b0;
      repeat (8) @(posedge ref_clk);
      {data_strobe_one, port_chip_select_n} <= 2'h3;
      repeat (8) @(posedge ref_clk);
      {data_strobe_two, port_chip_select_n} <= 2'h2;
      chk(16'(seen_busy), 16'h0000);
      done("strobe decode");
      rnd = lfsr(rnd);
      ctl = rnd[15:0];
      acc(SEL_CONTROL, 1'b0, HALF_FIRST, ctl, 1'b0, 16'h0000);
      acc(SEL_CONTROL, ACCESS_READ, HALF_FIRST, 16'h0000, 1'b0, ctl);
      acc(SEL_CONTROL, ACCESS_READ, HALF_FIRST, 16'h0000, 1'b1, ctl);
      chk(16'(seen_busy), 16'h0000);
      done("control");
      for (int lg = 0; lg < 2; lg++) begin
         lag <= (lg == 1) ? 4'h9 : 4'h0;
         rnd = lfsr(rnd);
         w0 = rnd;
         rnd = lfsr(rnd);
         w1 = rnd;
         a = 32'h0000_0010 + 32'(lg * 32);
         wr_word(SEL_ADDRESS, a);
         wr_word(SEL_DATA_FIXED, w1);
         seen_busy = 1'b0;
         rd_word(SEL_DATA_FIXED, w1);
         chk(16'(seen_busy), 16'h0001);
         wr_word(SEL_DATA_INC, w0);
         wr_word(SEL_DATA_INC, w1);
         if (lg == 1) begin
            // Chip select is seen two flops late, so each probe waits for it to arrive.
            @(posedge ref_clk);
            port_chip_select_n <= 1'b1;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(16'(port_ready_n), 16'h0000);
            @(posedge ref_clk);
            port_chip_select_n <= 1'b0;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(16'(port_ready_n), 16'h0001);
         end
         wr_word(SEL_ADDRESS, a);
         rd_word(SEL_DATA_INC, w0);
         rd_word(SEL_DATA_INC, w1);
         acc(SEL_ADDRESS, ACCESS_READ, HALF_FIRST, 16'h0000, 1'b0, 16'(a + 2 * ADDRESS_STEP));
         done("data words");
      end
      wait_low();
      chk(16'(exp_q.size()), 16'h0000);
      stop_test();
   end
endmodule

bind host_port_handshake host_port_handshake_monitor host_port_handshake_monitor_inst (.ref_clk, .rst,
   .port_chip_select_n, .data_strobe_one, .data_strobe_two, .register_select, .read_write_select,
   .port_data_bus_oe, .port_ready_n, .aux_req, .aux_write, .aux_addr, .aux_ack);
